// ==== line_sync.sv ====
`timescale 1ns/1ps
module line_sync #(
  parameter int unsigned W = 2,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // Two flops per bit, first read only by second
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta[i] <= RESET_VAL[i];
          q[i] <= RESET_VAL[i];
        end else begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule // line_sync

// ==== smbus_pkg.sv ====
package smbus_pkg;
  // Clock and bus timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned SCL_HALF_NS = 5000;
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BUS_FREE_NS = 50000;
  localparam int unsigned BUS_FREE_CYC = (BUS_FREE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LOW_TIMEOUT_MS = 25;
  localparam int unsigned LOW_TIMEOUT_CYC = LOW_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned LOW_CNT_W = 21;

  // Byte layout
  localparam int unsigned DIR_BIT = 0;
  localparam int unsigned ADDR_MSB = 7;
  localparam int unsigned ADDR_LSB = 1;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Status codes, one per protocol state
  localparam logic [7:0] ST_IDLE_CODE = 8'hF8;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_MT_SLA_ACK = 8'h18;
  localparam logic [7:0] ST_MT_SLA_NACK = 8'h20;
  localparam logic [7:0] ST_MT_DATA_ACK = 8'h28;
  localparam logic [7:0] ST_MT_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_MR_SLA_ACK = 8'h40;
  localparam logic [7:0] ST_MR_SLA_NACK = 8'h48;
  localparam logic [7:0] ST_MR_DATA_ACK = 8'h50;
  localparam logic [7:0] ST_MR_DATA_NACK = 8'h58;
  localparam logic [7:0] ST_SR_SLA_ACK = 8'h60;
  localparam logic [7:0] ST_SR_ARB_SLA = 8'h68;
  localparam logic [7:0] ST_SR_GC_ACK = 8'h70;
  localparam logic [7:0] ST_SR_DATA_ACK = 8'h80;
  localparam logic [7:0] ST_SR_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_SR_STOP = 8'hA0;
  localparam logic [7:0] ST_ST_SLA_ACK = 8'hA8;
  localparam logic [7:0] ST_ST_ARB_SLA = 8'hB0;
  localparam logic [7:0] ST_ST_DATA_ACK = 8'hB8;
  localparam logic [7:0] ST_ST_DATA_NACK = 8'hC0;
  localparam logic [7:0] ST_TIMEOUT = 8'h00;

  // Synchronised bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } line_t;
  localparam line_t LINE_IDLE = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE, S_START, S_XFER, S_WAIT, S_STOP
  } state_t;
endpackage

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic START_REQ = 1'b0, STOP_REQ = 1'b0, CLEAR_EVENT = 1'b0;
  logic tb_scl = 1'b1, tb_sda = 1'b1, stretch = 1'b0;
  logic ENABLE = 1'b1, ACK_EN = 1'b1, GC_EN = 1'b0;
  logic SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, EVENT, BUS_BUSY, MASTER, TIMEOUT;
  logic p_scl_oe, p_sda_oe;
  logic [7:0] TX_DATA = 8'h00;
  logic [7:0] RX_DATA, STATUS, p_rx;
  wire logic scl;
  wire logic sda;
  int num_errors = 0;
  int n_checks = 0;
  // Open-drain wires with pull-ups
  assign scl = ~SCL_OE & ~p_scl_oe & tb_scl;
  assign sda = ~SDA_OE & ~p_sda_oe & tb_sda;
  two_wire_interface #(.SCL_HALF_CYC(4), .BUS_FREE_CYC(20),
    .LOW_TIMEOUT_CYC(200)) dut (.CLK(CLK), .RST_N(RST_N), .ENABLE(ENABLE),
    .START_REQ(START_REQ), .STOP_REQ(STOP_REQ), .CLEAR_EVENT(CLEAR_EVENT),
    .ACK_EN(ACK_EN), .OWN_ADDR(7'h15), .GC_EN(GC_EN), .TX_DATA(TX_DATA),
    .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .RX_DATA(RX_DATA), .EVENT(EVENT),
    .STATUS(STATUS), .BUS_BUSY(BUS_BUSY), .MASTER(MASTER),
    .START_PENDING(), .STOP_PENDING(), .TIMEOUT(TIMEOUT));
  slave_model #(.MY_ADDR(7'h2A)) peer (.scl(scl), .sda(sda),
    .stretch(stretch), .scl_oe(p_scl_oe), .sda_oe(p_sda_oe), .rx(p_rx));
  // Clock
  initial forever #10 CLK = ~CLK;
  task tick;
    @(posedge CLK);
    #1;
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wait_ev;
    int i;
    for (i = 0; i < 4000 && EVENT !== 1'b1; i++) tick;
    if (EVENT !== 1'b1) begin
      chk("EVENT", 8'h01, {7'h00, EVENT});
      results;
    end
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 4000 && MASTER !== 1'b0; i++) tick;
    repeat (4) tick;
    chk("MASTER", 8'h00, {7'h00, MASTER});
  endtask
  task start;
    START_REQ = 1'b1;
    tick;
    START_REQ = 1'b0;
    wait_ev;
  endtask
  // Next byte, optional stop, then release the event
  task go(input logic [7:0] d, input logic sto);
    TX_DATA = d;
    STOP_REQ = sto;
    tick;
    STOP_REQ = 1'b0;
    CLEAR_EVENT = 1'b1;
    tick;
    CLEAR_EVENT = 1'b0;
  endtask
  task t_reset;
    chk("STATUS", smbus_pkg::ST_IDLE_CODE, STATUS);
    chk("idle", 8'h00, {4'h0, SCL_OE, SDA_OE, BUS_BUSY, EVENT});
  endtask
  task t_write;
    start;
    chk("STATUS", smbus_pkg::ST_START, STATUS);
    stretch = 1'b1;
    go(8'h54, 1'b0);
    repeat (50) tick;
    stretch = 1'b0;
    wait_ev;
    chk("STATUS", smbus_pkg::ST_MT_SLA_ACK, STATUS);
    go(8'hC3, 1'b0);
    wait_ev;
    chk("STATUS", smbus_pkg::ST_MT_DATA_ACK, STATUS);
    go(8'h00, 1'b1);
    wait_idle;
    chk("peer byte", 8'hC3, p_rx);
    chk("BUS_BUSY", 8'h00, {7'h00, BUS_BUSY});
  endtask
  task t_addr(input logic [7:0] a, input logic [7:0] exp);
    start;
    go(a, 1'b0);
    wait_ev;
    chk("STATUS", exp, STATUS);
    go(8'h00, 1'b1);
    wait_idle;
  endtask
  // Bench acts as master: eight bits and the ack clock, SCL left low
  task sbyte(input logic [7:0] b, input logic ack);
    int i;
    for (i = 8; i >= 0; i--) begin
      tb_scl = 1'b0;
      repeat (2) tick;
      tb_sda = (i > 0) ? b[i-1] : 1'b1;
      repeat (2) tick;
      tb_scl = 1'b1;
      repeat (2) tick;
      if (i == 0) chk("ack", {7'h00, ~ack}, {7'h00, sda});
      repeat (2) tick;
    end
    tb_scl = 1'b0;
  endtask
  // Bench STOP from SCL low
  task sstop;
    tb_sda = 1'b0;
    repeat (4) tick;
    tb_scl = 1'b1;
    repeat (4) tick;
    tb_sda = 1'b1;
  endtask
  task t_gc;
    GC_EN = 1'b1;
    tb_sda = 1'b0;
    repeat (4) tick;
    sbyte(8'h00, 1'b1);
    wait_ev;
    chk("STATUS", smbus_pkg::ST_SR_GC_ACK, STATUS);
    go(8'h00, 1'b0);
    sstop;
    wait_ev;
    chk("STATUS", smbus_pkg::ST_SR_STOP, STATUS);
    go(8'h00, 1'b0);
    ACK_EN = 1'b0;
    tb_sda = 1'b0;
    repeat (4) tick;
    sbyte(8'h00, 1'b0);
    repeat (4) tick;
    chk("EVENT", 8'h00, {7'h00, EVENT});
    sstop;
    ACK_EN = 1'b1;
    GC_EN = 1'b0;
  endtask
  task t_slave;
    tb_sda = 1'b0;
    repeat (4) tick;
    sbyte(8'h2A, 1'b1);
    wait_ev;
    chk("STATUS", smbus_pkg::ST_SR_SLA_ACK, STATUS);
    go(8'h00, 1'b0);
    wait_ev;
    chk("STATUS", smbus_pkg::ST_TIMEOUT, STATUS);
    chk("OE", 8'h00, {6'h00, SCL_OE, SDA_OE});
    tb_scl = 1'b1;
    go(8'h00, 1'b0);
    start;
    chk("STATUS", smbus_pkg::ST_START, STATUS);
    go(8'h00, 1'b1);
    wait_idle;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge CLK);
    #1 RST_N = 1'b1;
    tick;
    t_reset;
    t_write;
    t_addr(8'h66, smbus_pkg::ST_MT_SLA_NACK);
    t_addr(8'h55, smbus_pkg::ST_MR_SLA_ACK);
    t_slave;
    t_gc;
    results;
  end
endmodule // tb

// ==== two_wire_interface.sv ====
`timescale 1ns/1ps
module two_wire_interface #(
  parameter int unsigned SCL_HALF_CYC = smbus_pkg::SCL_HALF_CYC,
  parameter int unsigned BUS_FREE_CYC = smbus_pkg::BUS_FREE_CYC,
  parameter int unsigned LOW_TIMEOUT_CYC = smbus_pkg::LOW_TIMEOUT_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ENABLE,
  input wire logic START_REQ,
  input wire logic STOP_REQ,
  input wire logic CLEAR_EVENT,
  input wire logic ACK_EN,
  input wire logic [6:0] OWN_ADDR,
  input wire logic GC_EN,
  input wire logic [7:0] TX_DATA,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic [7:0] RX_DATA,
  output logic EVENT,
  output logic [7:0] STATUS,
  output logic BUS_BUSY,
  output logic MASTER,
  output logic START_PENDING,
  output logic STOP_PENDING,
  output logic TIMEOUT
);
  localparam int unsigned CW = smbus_pkg::CNT_W;
  localparam int unsigned LW = smbus_pkg::LOW_CNT_W;

  smbus_pkg::line_t pins;
  smbus_pkg::line_t ln;
  smbus_pkg::line_t prev;
  smbus_pkg::line_t next_prev;
  logic busy, next_busy;
  logic [CW-1:0] free_cnt, next_free_cnt;
  logic [LW-1:0] low_cnt, next_low_cnt;
  logic scl_rise, scl_fall, start_det, stop_det, free_hit, timeout_hit;

  smbus_pkg::state_t state, next_state;
  logic [1:0] phase, next_phase;
  logic [CW-1:0] cnt, next_cnt;
  logic scl_low, next_scl_low;
  logic sda_low, next_sda_low;
  logic [7:0] shreg, next_shreg;
  logic [3:0] bitcnt, next_bitcnt;
  logic tx, next_tx;
  logic dir, next_dir;
  logic addr_phase, next_addr_phase;
  logic master, next_master;
  logic addressed, next_addressed;
  logic arb_lost, next_arb_lost;
  logic ack_seen, next_ack_seen;
  logic rep, next_rep;
  logic si, next_si;
  logic start_request_bit, next_sta;
  logic sto, next_sto;
  logic [7:0] status, next_status;
  logic [7:0] rx_data, next_rx_data;
  logic timeout_pulse, next_timeout_pulse;
  logic drive_level;
  logic half_done, match, is_gc, tx_first;

  // Pins into the clock domain
  assign pins.scl = SCL_IN;
  assign pins.sda = SDA_IN;
  line_sync #(.W(2), .RESET_VAL(smbus_pkg::LINE_IDLE)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(pins),
    .q(ln)
  );

  // Bus monitor: edges, conditions, free and low timers
  always_comb begin
    scl_rise = ln.scl & ~prev.scl;
    scl_fall = ~ln.scl & prev.scl;
    start_det = prev.scl & ln.scl & prev.sda & ~ln.sda;
    stop_det = prev.scl & ln.scl & ~prev.sda & ln.sda;
    free_hit = (free_cnt == CW'(BUS_FREE_CYC));
    timeout_hit = ~ln.scl & (low_cnt == LW'(LOW_TIMEOUT_CYC - 1));
    next_prev = ln;
    next_free_cnt = '0;
    if (ln.scl && ln.sda) begin
      next_free_cnt = free_hit ? free_cnt : free_cnt + CW'(1);
    end
    next_low_cnt = '0;
    if (!ln.scl) begin
      next_low_cnt = (low_cnt == LW'(LOW_TIMEOUT_CYC)) ? low_cnt
                     : low_cnt + LW'(1);
    end
    next_busy = busy;
    if (start_det) begin
      next_busy = 1'b1;
    end else if (stop_det || free_hit) begin
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prev <= smbus_pkg::LINE_IDLE;
      free_cnt <= '0;
      low_cnt <= '0;
      busy <= 1'b0;
    end else begin
      prev <= next_prev;
      free_cnt <= next_free_cnt;
      low_cnt <= next_low_cnt;
      busy <= next_busy;
    end
  end

  // Address match for the acknowledge slot
  always_comb begin
    is_gc = GC_EN && (shreg[smbus_pkg::ADDR_MSB:smbus_pkg::ADDR_LSB]
                      == smbus_pkg::GC_ADDR);
    match = ACK_EN && (is_gc || (shreg[smbus_pkg::ADDR_MSB:smbus_pkg::ADDR_LSB]
                                 == OWN_ADDR));
    half_done = (cnt == CW'(SCL_HALF_CYC - 1));
    tx_first = (addr_phase && master) || tx;
  end

  // Protocol engine next state
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_cnt = cnt + CW'(1);
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_tx = tx;
    next_dir = dir;
    next_addr_phase = addr_phase;
    next_master = master;
    next_addressed = addressed;
    next_arb_lost = arb_lost;
    next_ack_seen = ack_seen;
    next_rep = rep;
    next_si = si;
    next_sta = start_request_bit;
    next_sto = sto;
    next_status = status;
    next_rx_data = rx_data;
    next_timeout_pulse = 1'b0;
    // Clears first, so a set below wins
    if (CLEAR_EVENT) begin
      next_si = 1'b0;
    end
    if (stop_det) begin
      next_sto = 1'b0;
    end
    unique case (state)
      smbus_pkg::S_IDLE: begin
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
        next_cnt = '0;
        if (start_det) begin
          next_state = smbus_pkg::S_XFER;
          next_bitcnt = '0;
          next_tx = 1'b0;
          next_addr_phase = 1'b1;
          next_arb_lost = 1'b0;
          next_addressed = 1'b0;
        end else if (start_request_bit && !busy) begin
          next_state = smbus_pkg::S_START;
          next_phase = 2'h0;
          next_master = 1'b1;
          next_rep = 1'b0;
        end
      end
      smbus_pkg::S_START: begin
        unique case (phase)
          2'h0: if (half_done) begin
            next_scl_low = 1'b0;
            next_phase = 2'h1;
            next_cnt = '0;
          end
          2'h1: if (!ln.scl) begin
            next_cnt = '0;
          end else if (half_done) begin
            next_sda_low = 1'b1;
            next_phase = 2'h2;
            next_cnt = '0;
          end
          2'h2: if (half_done) begin
            next_scl_low = 1'b1;
            next_phase = 2'h3;
            next_cnt = '0;
          end
          2'h3: if (half_done) begin
            next_si = 1'b1;
            next_sta = 1'b0;
            next_status = rep ? smbus_pkg::ST_RSTART : smbus_pkg::ST_START;
            next_state = smbus_pkg::S_WAIT;
            next_addr_phase = 1'b1;
            next_arb_lost = 1'b0;
          end
        endcase
      end
      smbus_pkg::S_XFER: begin
        // Master clock: low half, release, wait real high, high half
        if (master) begin
          if (scl_low) begin
            if (half_done) begin
              next_scl_low = 1'b0;
              next_cnt = '0;
            end
          end else if (!ln.scl) begin
            next_cnt = '0;
          end else if (half_done) begin
            next_scl_low = 1'b1;
            next_cnt = '0;
          end
        end
        // Sample on rising SCL
        if (scl_rise) begin
          next_bitcnt = bitcnt + 4'h1;
          if (bitcnt < smbus_pkg::BIT_ACK) begin
            next_shreg = {shreg[6:0], ln.sda};
            if (master && tx && !sda_low && !ln.sda) begin
              next_master = 1'b0;
              next_arb_lost = 1'b1;
              next_tx = 1'b0;
              next_scl_low = 1'b0;
            end
          end else begin
            next_ack_seen = ~ln.sda;
          end
        end
        // Drive on falling SCL, end of byte after the ack clock
        if (scl_fall) begin
          if (bitcnt < smbus_pkg::BIT_ACK) begin
            next_sda_low = tx & ~shreg[7];
          end else if (bitcnt == smbus_pkg::BIT_ACK) begin
            next_sda_low = ~tx & (addr_phase ? match : ACK_EN);
          end else begin
            next_sda_low = 1'b0;
            next_scl_low = 1'b1;
            next_state = smbus_pkg::S_WAIT;
            next_si = 1'b1;
            next_addr_phase = 1'b0;
            if (master) begin
              if (addr_phase) begin
                next_tx = ~dir;
                if (dir) begin
                  next_status = ack_seen ? smbus_pkg::ST_MR_SLA_ACK
                                         : smbus_pkg::ST_MR_SLA_NACK;
                end else begin
                  next_status = ack_seen ? smbus_pkg::ST_MT_SLA_ACK
                                         : smbus_pkg::ST_MT_SLA_NACK;
                end
              end else if (tx) begin
                next_status = ack_seen ? smbus_pkg::ST_MT_DATA_ACK
                                       : smbus_pkg::ST_MT_DATA_NACK;
              end else begin
                next_rx_data = shreg;
                next_status = sda_low ? smbus_pkg::ST_MR_DATA_ACK
                                      : smbus_pkg::ST_MR_DATA_NACK;
              end
            end else if (addr_phase) begin
              if (sda_low) begin
                next_addressed = 1'b1;
                next_dir = shreg[smbus_pkg::DIR_BIT];
                next_tx = shreg[smbus_pkg::DIR_BIT];
                if (shreg[smbus_pkg::DIR_BIT]) begin
                  next_status = arb_lost ? smbus_pkg::ST_ST_ARB_SLA
                                         : smbus_pkg::ST_ST_SLA_ACK;
                end else if (arb_lost) begin
                  next_status = smbus_pkg::ST_SR_ARB_SLA;
                end else begin
                  next_status = is_gc ? smbus_pkg::ST_SR_GC_ACK
                                      : smbus_pkg::ST_SR_SLA_ACK;
                end
              end else if (arb_lost) begin
                next_status = smbus_pkg::ST_ARB_LOST;
              end else begin
                next_state = smbus_pkg::S_IDLE;
                next_si = si & ~CLEAR_EVENT;
              end
            end else if (tx) begin
              next_addressed = ack_seen;
              next_status = ack_seen ? smbus_pkg::ST_ST_DATA_ACK
                                     : smbus_pkg::ST_ST_DATA_NACK;
            end else begin
              next_rx_data = shreg;
              next_status = sda_low ? smbus_pkg::ST_SR_DATA_ACK
                                    : smbus_pkg::ST_SR_DATA_NACK;
            end
          end
        end
      end
      smbus_pkg::S_WAIT: begin
        next_cnt = '0;
        next_scl_low = 1'b1;
        if (!si) begin
          if (master && sto) begin
            next_state = smbus_pkg::S_STOP;
            next_phase = 2'h0;
            next_sda_low = 1'b1;
          end else if (master && start_request_bit) begin
            next_state = smbus_pkg::S_START;
            next_phase = 2'h0;
            next_rep = 1'b1;
            next_sda_low = 1'b0;
          end else if (!master && (!addressed || sto)) begin
            next_state = smbus_pkg::S_IDLE;
            next_sto = 1'b0;
            next_addressed = 1'b0;
          end else begin
            next_state = smbus_pkg::S_XFER;
            next_bitcnt = '0;
            next_tx = tx_first;
            if (addr_phase && master) begin
              next_addr_phase = 1'b1;
              next_dir = TX_DATA[smbus_pkg::DIR_BIT];
            end
            if (tx_first) begin
              next_shreg = TX_DATA;
            end
            next_sda_low = tx_first & ~TX_DATA[7];
            next_scl_low = master;
          end
        end
      end
      smbus_pkg::S_STOP: begin
        unique case (phase)
          2'h0: if (half_done) begin
            next_scl_low = 1'b0;
            next_phase = 2'h1;
            next_cnt = '0;
          end
          2'h1: if (!ln.scl) begin
            next_cnt = '0;
          end else if (half_done) begin
            next_sda_low = 1'b0;
            next_phase = 2'h2;
            next_cnt = '0;
          end
          default: if (half_done) begin
            next_state = smbus_pkg::S_IDLE;
            next_master = 1'b0;
            next_sto = 1'b0;
          end
        endcase
      end
    endcase
    // Foreign conditions seen during a transfer
    if ((state == smbus_pkg::S_XFER || state == smbus_pkg::S_WAIT) &&
        !master) begin
      if (stop_det) begin
        next_state = smbus_pkg::S_IDLE;
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
        next_addressed = 1'b0;
        if (addressed) begin
          next_si = 1'b1;
          next_status = smbus_pkg::ST_SR_STOP;
        end
      end else if (start_det) begin
        next_state = smbus_pkg::S_XFER;
        next_bitcnt = '0;
        next_tx = 1'b0;
        next_addr_phase = 1'b1;
        next_addressed = 1'b0;
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
      end
    end
    // Clock-low timeout drops the transfer, master role and line drives; pending START/STOP requests stay set
    if (timeout_hit) begin
      next_state = smbus_pkg::S_IDLE;
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
      next_master = 1'b0;
      next_addressed = 1'b0;
      next_si = 1'b1;
      next_status = smbus_pkg::ST_TIMEOUT;
      next_timeout_pulse = 1'b1;
    end
    if (!ENABLE) begin
      next_state = smbus_pkg::S_IDLE;
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
      next_master = 1'b0;
      next_addressed = 1'b0;
    end
    // Host requests, set wins over clear
    if (START_REQ) begin
      next_sta = 1'b1;
    end
    if (STOP_REQ) begin
      next_sto = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= smbus_pkg::S_IDLE;
      phase <= 2'h0;
      cnt <= '0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      shreg <= smbus_pkg::DATA_RESET;
      bitcnt <= 4'h0;
      tx <= 1'b0;
      dir <= 1'b0;
      addr_phase <= 1'b0;
      master <= 1'b0;
      addressed <= 1'b0;
      arb_lost <= 1'b0;
      ack_seen <= 1'b0;
      rep <= 1'b0;
      si <= 1'b0;
      start_request_bit <= 1'b0;
      sto <= 1'b0;
      status <= smbus_pkg::ST_IDLE_CODE;
      rx_data <= smbus_pkg::DATA_RESET;
      timeout_pulse <= 1'b0;
      drive_level <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cnt <= next_cnt;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      tx <= next_tx;
      dir <= next_dir;
      addr_phase <= next_addr_phase;
      master <= next_master;
      addressed <= next_addressed;
      arb_lost <= next_arb_lost;
      ack_seen <= next_ack_seen;
      rep <= next_rep;
      si <= next_si;
      start_request_bit <= next_sta;
      sto <= next_sto;
      status <= next_status;
      rx_data <= next_rx_data;
      timeout_pulse <= next_timeout_pulse;
      drive_level <= 1'b0;
    end
  end

  // Outputs straight from flops
  assign SCL_OUT = drive_level;
  assign SDA_OUT = drive_level;
  assign SCL_OE = scl_low;
  assign SDA_OE = sda_low;
  assign RX_DATA = rx_data;
  assign EVENT = si;
  assign STATUS = status;
  assign BUS_BUSY = busy;
  assign MASTER = master;
  assign START_PENDING = start_request_bit;
  assign STOP_PENDING = sto;
  assign TIMEOUT = timeout_pulse;
endmodule // two_wire_interface

// ==== two_wire_monitor.sv ====
`timescale 1ns/1ps
module two_wire_monitor #(
  parameter int unsigned BUS_FREE_CYC = 20
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic START_REQ,
  input wire logic STOP_REQ,
  input wire logic CLEAR_EVENT,
  input wire logic ENABLE,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SCL_OUT,
  input wire logic SCL_OE,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic EVENT,
  input wire logic [7:0] STATUS,
  input wire logic BUS_BUSY,
  input wire logic MASTER,
  input wire logic START_PENDING,
  input wire logic STOP_PENDING,
  input wire logic TIMEOUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [11:0] idle_cnt;
  logic [11:0] next_idle_cnt;
  // Cycles with both raw lines high
  always_comb begin
    next_idle_cnt = idle_cnt;
    if (!(SCL_IN && SDA_IN)) next_idle_cnt = 12'h000;
    else if (idle_cnt != 12'hFFF) next_idle_cnt = idle_cnt + 12'h001;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) idle_cnt <= 12'h000;
    else idle_cnt <= next_idle_cnt;
  end
  // Bus protocol checks
  pins_low_a: assert property (!SCL_OUT && !SDA_OUT)
    else $error("pin output driven high");
  to_release_a: assert property (TIMEOUT |-> !SCL_OE && !SDA_OE
    && EVENT && !MASTER && STATUS == smbus_pkg::ST_TIMEOUT)
    else $error("timeout did not release the bus");
  to_pulse_a: assert property (TIMEOUT |=> !TIMEOUT)
    else $error("timeout pulse too long");
  sta_flag_a: assert property (START_REQ |=> START_PENDING)
    else $error("start request lost");
  sto_flag_a: assert property (STOP_REQ |=> STOP_PENDING)
    else $error("stop request lost");
  ev_clear_a: assert property ($fell(EVENT) |-> $past(CLEAR_EVENT))
    else $error("event dropped without clear");
  hold_low_a: assert property (EVENT && SCL_OE && ENABLE && !CLEAR_EVENT
    |=> SCL_OE || TIMEOUT)
    else $error("clock released while event pending");
  bus_free_a: assert property (idle_cnt > BUS_FREE_CYC + 4 |-> !BUS_BUSY)
    else $error("bus still busy after idle interval");
  start_ev_a: assert property ($rose(EVENT) && STATUS == smbus_pkg::ST_START
    |-> MASTER && !START_PENDING)
    else $error("start event without master mode");
endmodule // two_wire_monitor

bind two_wire_interface two_wire_monitor #(.BUS_FREE_CYC(BUS_FREE_CYC)) mon (
  .CLK(CLK), .RST_N(RST_N), .START_REQ(START_REQ), .STOP_REQ(STOP_REQ),
  .CLEAR_EVENT(CLEAR_EVENT), .ENABLE(ENABLE), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .EVENT(EVENT), .STATUS(STATUS), .BUS_BUSY(BUS_BUSY),
  .MASTER(MASTER), .START_PENDING(START_PENDING),
  .STOP_PENDING(STOP_PENDING), .TIMEOUT(TIMEOUT));

// ==== two_wire_slave_model.sv ====
`timescale 1ns/1ps
module slave_model #(
  parameter logic [6:0] MY_ADDR = 7'h2A
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  output logic scl_oe,
  output logic sda_oe = 1'b0,
  output logic [7:0] rx = 8'h00
);
  logic [7:0] sh = 8'h00;
  logic hit = 1'b0;
  int n = 0;
  int nb = 0;
  // Clock held low on command only
  assign scl_oe = stretch;
  // START restarts the frame
  always @(negedge sda) begin
    if (scl) begin
      n = 0;
      nb = 0;
    end
  end
  // Sample data on the rising clock
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    n = n + 1;
  end
  // Ack after eight bits, release after the ninth
  always @(negedge scl) begin
    if (n == 8) begin
      if (nb == 0) hit = (sh[7:1] == MY_ADDR);
      if (nb != 0 && hit) rx = sh;
      sda_oe = hit;
    end
    if (n == 9) begin
      sda_oe = 1'b0;
      n = 0;
      nb = nb + 1;
    end
  end
endmodule // slave_model
